// *** include/oc_defines.svh ***
`ifndef OC_DEFINES_SVH
`define OC_DEFINES_SVH
// Contract
// R1: In PWM mode the first pulse appears on the output pin even with a timer prescale of 8, 64 or 256.
// R2: The timer control register holds a two-bit prescale select at bits 5:4 choosing 1:1, 1:8, 1:64 or 1:256.
// R3: Compare mode codes 001, 010 and 100 select one-shot compare.
// R4: In one-shot mode the interrupt flag is never set before the output pin has changed state.
// R5: Clearing the mode field re-initialises the unit and keeps the pin driven at its expected level.
// R6: Software should wait twice the prescale factor in CPU cycles after the flag before clearing the mode.
// R7: Instances one and two work in PWM mode from a prescaled timer.
// R8: Software should use a 1:1 prescale for instances three to six in PWM mode.
// R9: A match is the timer count equal to the compare value, sampled on the prescaled timer tick.

// ==========================================================================
// Register offsets (byte addresses).
`define OFS_TIMER_CTRL   8'h00
`define OFS_TIMER_PERIOD 8'h04
`define OFS_TIMER_COUNT  8'h08
`define OFS_COMPARE_CTRL 8'h0c
`define OFS_COMPARE_VAL  8'h10
`define OFS_DUTY_VAL     8'h14
`define OFS_IRQ_STATUS   8'h18
`define OFS_IRQ_ENABLE   8'h1c
`define OFS_IRQ_CLEAR    8'h20

// ==========================================================================
// Field positions and reset values.
`define TCTRL_ON_BIT     0
`define TCTRL_PS_HI      5
`define TCTRL_PS_LO      4
`define CCTRL_MODE_HI    2
`define CCTRL_MODE_LO    0
`define RST_PERIOD       16'hffff
`define IRQ_MATCH_BIT    0
`define IRQ_PERIOD_BIT   1
`define IRQ_WIDTH        2

// ==========================================================================
// Prescaler terminal counts, one less than the division ratio.
`define PS_LIMIT_DIV1    8'h00
`define PS_LIMIT_DIV8    8'h07
`define PS_LIMIT_DIV64   8'h3f
`define PS_LIMIT_DIV256  8'hff
`endif

// *** include/oc_pkg.sv ***
package oc_pkg;
  typedef enum logic [1:0] {ps_div1, ps_div8, ps_div64, ps_div256} prescale_t;
  typedef enum logic [2:0] {
    mode_off, mode_single_high, mode_single_low, mode_toggle,
    mode_single_pulse, mode_pulse_train, mode_pwm, mode_pwm_fault
  } compare_mode_t;
endpackage

// *** test/oc_checker.sv ***
`timescale 1ns/1ns
// ==========
// Port checker for the compare unit.
module oc_checker
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        compare_output_pin,
  input wire logic        irq
);
  logic [1:0] en_r;
  logic       rd;
  logic       wr;
  // New read or write requests on the bus.
  assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  // Shadow of the enable register, so enable writes do not look like events.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      en_r <= 2'h0;
    else if (wr && wb_adr_i == 8'h1c)
      en_r <= wb_dat_i[1:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_reset_quiet: assert property ($rose(rst_n) |-> !compare_output_pin && !irq)
    else $error("outputs not low after reset");
  chk_unmapped_zero: assert property (rd && wb_adr_i > 8'h20 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_clear_reads_zero: assert property (rd && wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0)
    else $error("clear register read not zero");
  chk_flag_after_pin: assert property ($rose(irq) && en_r == 2'h1 && $past(en_r, 2) == 2'h1
    && $past(en_r, 4) == 2'h1 |-> $past(compare_output_pin, 1) != $past(compare_output_pin, 3))
    else $error("flag raised without a pin change");
  chk_mode_clear_hold: assert property (wr && wb_adr_i == 8'h0c && wb_dat_i[2:0] == 3'h0
    |=> ##2 $stable(compare_output_pin)[*2])
    else $error("pin moved after mode clear");
  chk_irq_mask_drop: assert property (wr && wb_adr_i == 8'h1c && wb_dat_i[1:0] == 2'h0
    |-> ##3 !irq)
    else $error("irq not masked");
  cover property ($rose(irq));
  cover property ($rose(compare_output_pin));
  cover property (rd && wb_adr_i > 8'h20);
endmodule

bind output_compare oc_checker oc_checker_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .compare_output_pin(compare_output_pin), .irq(irq));

// *** test/output_compare_oneshot_pwm_bench.sv ***
`timescale 1ns/1ns
// ==========
// Bench: register calls over Wishbone, pin watched by the load model.
module output_compare_oneshot_pwm_bench;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, clr = 0;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0, q, rdat;
  logic        ack, pin, irq;
  int          fails = 0, samples_checked = 0, rises, w0, w1, n;
  int          f[4] = '{1, 8, 64, 256};
  logic [2:0]  code[3] = '{3'h1, 3'h2, 3'h4};
  logic        at_flag[3] = '{1, 0, 1}, final_pin[3] = '{1, 0, 0};
  logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h18, 8'h20, 8'h40};
  logic [31:0] rv[5] = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'h0};
  always #50 clk = ~clk;
  output_compare output_compare_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .compare_output_pin(pin), .irq(irq));
  pin_receiver pin_receiver_inst (.clk(clk), .pin(pin), .clr(clr), .rises(rises), .width0(w0),
    .width1(w1));
  // ==========
  // Closing report.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Compares one value and reports a difference.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    q = rdat;
    {cyc, stb} <= 2'h0;
    if (k == 20)
    begin
      fails++;
      tally_and_finish();
    end
  endtask
  // Counts out a bounded wait; a used-up bound ends the run.
  task automatic bound(input int lim);
    if (++n >= lim)
    begin
      fails++;
      tally_and_finish();
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 5; i++)
    begin
      wb(0, ra[i], 0);
      check("reset value", q, rv[i]);
    end
    wb(1, 8'h00, 32'h30);
    wb(0, 8'h00, 0);
    check("prescale field", q, 32'h30);
    wb(1, 8'h1c, 1);
    // One-shot codes at 1:8; flag must find the pin already moved.
    for (int i = 0; i < 3; i++)
    begin
      wb(1, 8'h08, 0);
      wb(1, 8'h10, 2);
      wb(1, 8'h14, 4);
      wb(1, 8'h0c, {29'h0, code[i]});
      wb(1, 8'h00, 32'h11);
      n = 0;
      do
      begin
        wb(0, 8'h18, 0);
        bound(100);
      end
      while (q[0] !== 1'b1);
      check("pin at flag", pin, at_flag[i]);
      check("irq raised", irq, 1);
      repeat (40) @(posedge clk);
      check("pin after shot", pin, final_pin[i]);
      wb(1, 8'h0c, 0);
      wb(1, 8'h00, 0);
      repeat (8) @(posedge clk);
      check("pin held", pin, final_pin[i]);
      wb(1, 8'h1c, 0);
      wb(0, 8'h18, 0);
      check("irq masked", irq, 0);
      wb(1, 8'h1c, 1);
      wb(0, 8'h18, 0);
      check("irq unmasked", irq, 1);
      wb(1, 8'h20, 1);
      wb(0, 8'h18, 0);
      check("status cleared", q, 0);
      check("irq cleared", irq, 0);
    end
    // PWM at every prescale; this unit stands for instance one.
    for (int i = 0; i < 4; i++)
    begin
      wb(1, 8'h00, 0);
      wb(1, 8'h08, 0);
      wb(1, 8'h04, 5);
      wb(1, 8'h14, 3);
      wb(1, 8'h0c, 6 + (i & 1));
      clr <= 1;
      @(posedge clk);
      clr <= 0;
      wb(1, 8'h00, (i << 4) | 1);
      n = 0;
      while (w1 == 0)
      begin
        @(posedge clk);
        bound(6000);
      end
      check("first pulse", w0, 3 * f[i]);
      check("pulse width", w1, 3 * f[i]);
      // Zero duty parks the pin low, so the next run starts from a low pin.
      wb(1, 8'h14, 0);
      repeat (7 * f[i]) @(posedge clk);
      check("pin low at zero duty", pin, 0);
    end
    wb(1, 8'h00, 0);
    wb(0, 8'h18, 0);
    check("match and wrap flags", q & 32'h3, 32'h3);
    wb(1, 8'h20, 3);
    wb(0, 8'h18, 0);
    check("both flags cleared", q, 0);
    // Pulse train, then toggle, at 1:1 with period 5.
    for (int i = 0; i < 2; i++)
    begin
      wb(1, 8'h08, 0);
      wb(1, 8'h10, i ? 0 : 1);
      wb(1, 8'h14, 3);
      wb(1, 8'h0c, i ? 3 : 5);
      clr <= 1;
      @(posedge clk);
      clr <= 0;
      wb(1, 8'h00, 1);
      n = 0;
      while (w1 == 0)
      begin
        @(posedge clk);
        bound(200);
      end
      check("train or toggle width", w0, i ? 6 : 2);
      check("second train or toggle width", w1, i ? 6 : 2);
      wb(1, 8'h00, 0);
    end
    tally_and_finish();
  end
endmodule

// *** test/pin_receiver.sv ***
`timescale 1ns/1ns
// ==========
// Load on the compare pin: counts pulses and times the first two.
module pin_receiver
(
  input wire logic clk,
  input wire logic pin,
  input wire logic clr,
  output int       rises,
  output int       width0,
  output int       width1
);
  int   run_r;
  logic last_r;
  // High time is counted in clocks and latched at the falling edge of each of the first two pulses.
  always @(posedge clk)
  begin
    last_r <= pin;
    run_r <= pin ? run_r + 1 : 0;
    if (clr)
      {rises, width0, width1} <= '0;
    else if (pin && !last_r)
      rises <= rises + 1;
    else if (!pin && last_r && rises == 1)
      width0 <= run_r;
    else if (!pin && last_r && rises == 2)
      width1 <= run_r;
  end
endmodule

// *** verilog/oc_prescaler.sv ***
`timescale 1ns/1ns
`include "oc_defines.svh"
// ==========================================================================
// Prescaler: one tick per 1, 8, 64 or 256 clocks while running.
module oc_prescaler
  import oc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      run,
  input  wire prescale_t sel,
  output logic           tick
);
  logic [7:0] cnt_r;
  logic [7:0] limit;

  // Terminal count for the selected ratio.
  always_comb
  begin
    unique case (sel)
      ps_div1:   limit = `PS_LIMIT_DIV1;
      ps_div8:   limit = `PS_LIMIT_DIV8;
      ps_div64:  limit = `PS_LIMIT_DIV64;
      ps_div256: limit = `PS_LIMIT_DIV256;
    endcase
  end

  // Divider restarts when the timer stops, so the first tick is a full period.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 8'h00;
    else if (!run || cnt_r >= limit)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_r + 8'h01;
  end

  assign tick = run && (cnt_r >= limit); // [R2]
endmodule

// *** verilog/output_compare.sv ***
`timescale 1ns/1ns
`include "oc_defines.svh"
// ==========================================================================
// Timer plus output compare unit with a classic Wishbone slave.
module output_compare
  import oc_pkg::*;
#(
  parameter int TW = 16
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             compare_output_pin,
  output logic             irq
);
  // The timer must fit the 32-bit data bus and count at least to three.
  if (TW < 2 || TW > 32)
  begin : g_tw_check
    $error("TW must be 2..32");
  end

  logic [TW-1:0]          period_r;
  logic [TW-1:0]          count_r;
  logic [TW-1:0]          cmp_r;
  logic [TW-1:0]          duty_r;
  logic                   timer_on_r;
  prescale_t              timer_prescale_select;
  compare_mode_t          compare_mode_select;
  logic [`IRQ_WIDTH-1:0]  status_r;
  logic [`IRQ_WIDTH-1:0]  enable_r;
  logic                   pin_r;
  logic                   done_r;
  logic                   flag_pend_r;
  logic                   tick;
  logic                   wr;
  logic                   rd;
  logic                   cmp_hit;
  logic                   duty_hit;
  logic                   wrap;
  logic                   pin_nxt;
  logic [31:0]            wnew;
  logic [31:0]            wmask;
  logic [`IRQ_WIDTH-1:0]  ev;
  logic [31:0]            rdata;

  // Turn a byte-enabled write into a new register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // One-shot mode codes.
  function automatic logic is_oneshot(input compare_mode_t m);
    return (m == mode_single_high) || (m == mode_single_low) || (m == mode_single_pulse);
  endfunction

  function automatic logic is_pwm(input compare_mode_t m);
    return (m == mode_pwm) || (m == mode_pwm_fault);
  endfunction

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  // Byte-enabled write data and its byte mask, so partial writes keep old bytes except in the timer and compare control registers.
  assign wnew  = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign wmask = merge(32'h0000_0000, 32'hffff_ffff, wb_sel_i);

  // ==========================================================================
  // Bus acknowledge: one cycle after the strobe, dropped the next cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // Read mux; unmapped offsets read zero.
  always_comb
  begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      `OFS_TIMER_CTRL:
      begin
        rdata[`TCTRL_ON_BIT] = timer_on_r;
        rdata[`TCTRL_PS_HI:`TCTRL_PS_LO] = timer_prescale_select;
      end
      `OFS_TIMER_PERIOD: rdata[TW-1:0] = period_r;
      `OFS_TIMER_COUNT:  rdata[TW-1:0] = count_r;
      `OFS_COMPARE_CTRL: rdata[`CCTRL_MODE_HI:`CCTRL_MODE_LO] = compare_mode_select;
      `OFS_COMPARE_VAL:  rdata[TW-1:0] = cmp_r;
      `OFS_DUTY_VAL:     rdata[TW-1:0] = duty_r;
      `OFS_IRQ_STATUS:   rdata[`IRQ_WIDTH-1:0] = status_r;
      `OFS_IRQ_ENABLE:   rdata[`IRQ_WIDTH-1:0] = enable_r;
      default:           rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h0000_0000;
    else if (rd)
      wb_dat_o <= rdata;
  end

  // ==========================================================================
  // Configuration registers written by software.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_on_r            <= 1'b0;
      timer_prescale_select <= ps_div1;
      period_r              <= TW'(`RST_PERIOD);
      cmp_r                 <= '0;
      duty_r                <= '0;
      compare_mode_select   <= mode_off;
      enable_r              <= '0;
    end
    else if (wr)
    begin
      unique case (wb_adr_i)
        `OFS_TIMER_CTRL:
        begin
          timer_on_r            <= wnew[`TCTRL_ON_BIT];
          timer_prescale_select <= prescale_t'(wnew[`TCTRL_PS_HI:`TCTRL_PS_LO]); // [R2]
        end
        `OFS_TIMER_PERIOD: period_r <= (period_r & ~wmask[TW-1:0]) | wnew[TW-1:0];
        `OFS_COMPARE_CTRL: compare_mode_select <= // [R3]
          compare_mode_t'(wnew[`CCTRL_MODE_HI:`CCTRL_MODE_LO]);
        `OFS_COMPARE_VAL:  cmp_r <= (cmp_r & ~wmask[TW-1:0]) | wnew[TW-1:0];
        `OFS_DUTY_VAL:     duty_r <= (duty_r & ~wmask[TW-1:0]) | wnew[TW-1:0];
        `OFS_IRQ_ENABLE:
          enable_r <= (enable_r & ~wmask[`IRQ_WIDTH-1:0]) | wnew[`IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Time base.
  oc_prescaler oc_prescaler_inst
  (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (timer_on_r),
    .sel   (timer_prescale_select),
    .tick  (tick)
  );

  assign wrap = tick && (count_r == period_r);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= '0;
    else if (wr && wb_adr_i == `OFS_TIMER_COUNT)
      count_r <= (count_r & ~wmask[TW-1:0]) | wnew[TW-1:0];
    else if (wrap)
      count_r <= '0;
    else if (tick)
      count_r <= count_r + TW'(1);
  end

  // Matches are only seen on a prescaled tick.
  assign cmp_hit  = tick && (count_r == cmp_r);  // [R9]
  assign duty_hit = tick && (count_r == duty_r); // [R9]

  // ==========================================================================
  // Output pin decision. PWM raises the pin at count zero unless the duty value is zero,
  // including the very first period after the timer starts, independent of the prescale.
  always_comb
  begin
    pin_nxt = pin_r;
    unique case (compare_mode_select)
      mode_off:          pin_nxt = pin_r; // [R5]
      mode_single_high:  if (cmp_hit && !done_r) pin_nxt = 1'b1;
      mode_single_low:   if (cmp_hit && !done_r) pin_nxt = 1'b0;
      mode_toggle:       if (cmp_hit) pin_nxt = !pin_r;
      mode_single_pulse: if (!done_r) pin_nxt = cmp_hit ? 1'b1 : (duty_hit ? 1'b0 : pin_r);
      mode_pulse_train:  pin_nxt = cmp_hit ? 1'b1 : (duty_hit ? 1'b0 : pin_r);
      mode_pwm, mode_pwm_fault:
        if (tick) // [R1] [R7]
          pin_nxt = (count_r == duty_r) ? 1'b0 : ((count_r == '0) ? 1'b1 : pin_r);
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_r <= 1'b0;
    else
      pin_r <= pin_nxt;
  end

  // One-shot completion; cleared only by selecting mode_off, which re-arms.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      done_r <= 1'b0;
    else if (compare_mode_select == mode_off)
      done_r <= 1'b0; // [R5]
    else if (is_oneshot(compare_mode_select) && !done_r &&
             ((compare_mode_select == mode_single_pulse) ? duty_hit : cmp_hit))
      done_r <= 1'b1;
  end

  // The flag is raised a cycle after the pin register takes its new level.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_pend_r <= 1'b0;
    else
      flag_pend_r <= (compare_mode_select != mode_off) && // [R4]
                     (is_pwm(compare_mode_select) ? (tick && count_r == '0) :
                      (cmp_hit && !(is_oneshot(compare_mode_select) && done_r)));
  end

  assign ev = {wrap, flag_pend_r};

  // ==========================================================================
  // Sticky status: a new event wins over a same-cycle clear.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_r <= '0;
    else if (wr && wb_adr_i == `OFS_IRQ_CLEAR)
      status_r <= (status_r & ~(wb_dat_i[`IRQ_WIDTH-1:0] & {`IRQ_WIDTH{wb_sel_i[0]}})) | ev;
    else
      status_r <= status_r | ev;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(status_r & enable_r);
  end

  assign compare_output_pin = pin_r;
endmodule
